//--- rtl/pmp_pkg.sv
package pmp_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [11:0] CONFIG_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;

	// Field positions in CONFIG
	localparam int unsigned CP_N_BIT      = 0;
	localparam int unsigned APP_LOCK_BIT  = 1;
	localparam int unsigned SAF_LOCK_BIT  = 2;
	localparam int unsigned BOOT_LOCK_BIT = 3;
	localparam int unsigned CFG_LOCK_BIT  = 4;
	localparam int unsigned DATA_CP_N_BIT = 8;

	// Reset value of CONFIG: both protections off, no region locked
	localparam logic [31:0] CONFIG_RST = 32'h0000_0101;

	// Field positions in STATUS
	localparam int unsigned EXT_CNT_LSB = 0;
	localparam int unsigned CPU_CNT_LSB = 16;
	localparam int unsigned CNT_W       = 16;
	localparam logic [15:0] CNT_RST     = 16'h0000;

	// Region sizes in words, boot at the bottom, storage area at the top
	localparam int unsigned BOOT_WORDS = 512;
	localparam int unsigned SAF_WORDS  = 128;

	// Memory read latency, fixed by the pipeline: mem_rd_en to data
	localparam int unsigned MEM_RD_LAT = 1;

	typedef enum logic [1:0] {
		PMP_REG_APP,
		PMP_REG_SAF,
		PMP_REG_BOOT,
		PMP_REG_CFG
	} pmp_region_t;

	typedef enum logic [1:0] {
		PMP_EXT_IDLE,
		PMP_EXT_RD,
		PMP_EXT_HOLD
	} pmp_ext_state_t;

endpackage : pmp_pkg

//--- rtl/pmp_region_chk.sv
module pmp_region_chk #(
	parameter int ADDR_W     = 11,
	parameter int BOOT_WORDS = pmp_pkg::BOOT_WORDS,
	parameter int SAF_WORDS  = pmp_pkg::SAF_WORDS
) (
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic                cfg_space,
	input  wire logic                app_region_write_lock,
	input  wire logic                storage_area_write_lock,
	input  wire logic                boot_region_write_lock,
	input  wire logic                config_region_write_lock,
	output pmp_pkg::pmp_region_t     region,
	output logic                     locked
);

	generate
		if (BOOT_WORDS + SAF_WORDS > (1 << ADDR_W) || ADDR_W > 16) begin : g_bad
			$error("pmp_region_chk: regions do not fit the address space");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] BOOT_LIM = ADDR_W'(BOOT_WORDS);
	localparam logic [ADDR_W-1:0] SAF_BASE =
		ADDR_W'((1 << ADDR_W) - SAF_WORDS);

	wire logic in_boot;
	wire logic in_saf;

	assign in_boot = (addr < BOOT_LIM);
	assign in_saf  = (SAF_WORDS != 0) && (addr >= SAF_BASE);

	assign region = cfg_space ? pmp_pkg::PMP_REG_CFG :
		in_boot ? pmp_pkg::PMP_REG_BOOT :
		in_saf ? pmp_pkg::PMP_REG_SAF : pmp_pkg::PMP_REG_APP;

	assign locked = (region == pmp_pkg::PMP_REG_CFG)
			? config_region_write_lock :
		(region == pmp_pkg::PMP_REG_BOOT) ? boot_region_write_lock :
		(region == pmp_pkg::PMP_REG_SAF) ? storage_area_write_lock :
		app_region_write_lock;

endmodule : pmp_region_chk

//--- rtl/pmp_ext_gate.sv
module pmp_ext_gate #(
	parameter int DATA_W = 14
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              ext_req,
	input  wire logic              ext_we,
	input  wire logic              code_protect_n,
	input  wire logic              grant,
	input  wire logic              rd_done,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic                   ext_take,
	output logic                   ext_mem_rd,
	output logic                   ext_mem_wr,
	output logic                   ext_ack,
	output logic                   ext_refused,
	output logic [DATA_W-1:0]      ext_rdata
);

	generate
		if (DATA_W < 1) begin : g_bad
			$error("pmp_ext_gate: data width must be positive");
		end
	endgenerate

	pmp_pkg::pmp_ext_state_t state;

	assign ext_take = ext_req && grant && (state == pmp_pkg::PMP_EXT_IDLE);

	assign ext_mem_rd = ext_take && code_protect_n && !ext_we;
	assign ext_mem_wr = ext_take && code_protect_n && ext_we;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state       <= pmp_pkg::PMP_EXT_IDLE;
			ext_ack     <= 1'b0;
			ext_refused <= 1'b0;
			ext_rdata   <= '0;
		end else begin
			ext_ack     <= 1'b0;
			ext_refused <= 1'b0;
			case (state)
				pmp_pkg::PMP_EXT_IDLE: begin
					if (ext_take && !code_protect_n) begin
						ext_ack     <= 1'b1;
						ext_refused <= 1'b1;
						ext_rdata   <= '0;
						state       <= pmp_pkg::PMP_EXT_HOLD;
					end else if (ext_take && ext_we) begin
						ext_ack <= 1'b1;
						state   <= pmp_pkg::PMP_EXT_HOLD;
					end else if (ext_take) begin
						state <= pmp_pkg::PMP_EXT_RD;
					end
				end
				pmp_pkg::PMP_EXT_RD: begin
					if (rd_done) begin
						ext_ack   <= 1'b1;
						ext_rdata <= mem_rdata;
						state     <= pmp_pkg::PMP_EXT_HOLD;
					end
				end
				pmp_pkg::PMP_EXT_HOLD: begin
					// A held request is not taken twice
					if (!ext_req) begin
						state <= pmp_pkg::PMP_EXT_IDLE;
					end
				end
				default: begin
					state <= pmp_pkg::PMP_EXT_IDLE;
				end
			endcase
		end
	end

endmodule : pmp_ext_gate

//--- rtl/pmp_protect.sv
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module pmp_protect #(
	parameter int ADDR_W     = 11,
	parameter int DATA_W     = 14,
	parameter int BOOT_WORDS = pmp_pkg::BOOT_WORDS,
	parameter int SAF_WORDS  = pmp_pkg::SAF_WORDS
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	input  wire logic              cpu_rd_req,
	input  wire logic              cpu_wr_req,
	input  wire logic              cpu_erase,
	input  wire logic              cpu_cfg_space,
	input  wire logic [ADDR_W-1:0] cpu_addr,
	input  wire logic [DATA_W-1:0] cpu_wdata,
	output logic [DATA_W-1:0]      cpu_rdata,
	output logic                   cpu_rd_valid,
	output logic                   cpu_wr_blocked,
	input  wire logic              ext_req,
	input  wire logic              ext_we,
	input  wire logic              ext_cfg_space,
	input  wire logic [ADDR_W-1:0] ext_addr,
	input  wire logic [DATA_W-1:0] ext_wdata,
	output logic                   ext_ack,
	output logic                   ext_refused,
	output logic [DATA_W-1:0]      ext_rdata,
	output logic                   mem_rd_en,
	output logic                   mem_wr_en,
	output logic                   mem_erase,
	output logic                   mem_cfg_space,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [DATA_W-1:0]      mem_wdata,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic                   data_protect_n
);

	generate
		if (DATA_W < 1 || DATA_W > 32 || ADDR_W < 1) begin : g_bad
			$error("pmp_protect: unsupported data or address width");
		end
	endgenerate

	// Configuration and status registers
	logic [31:0]              config_q;
	logic [pmp_pkg::CNT_W-1:0] ext_cnt;
	logic [pmp_pkg::CNT_W-1:0] cpu_cnt;

	// AHB-Lite data phase state
	logic        wr_pend;
	logic        rd_pend;
	logic [11:0] ph_addr;

	// Read return pipeline
	logic rd1_cpu;
	logic rd1_ext;
	logic rd2_cpu;
	logic rd2_ext;

	wire logic                code_protect_n;
	wire logic                app_lock;
	wire logic                saf_lock;
	wire logic                boot_lock;
	wire logic                cfg_lock;
	wire logic                ahb_go;
	wire logic                cfg_wr;
	wire logic                sts_wr;
	wire logic                cpu_busy;
	wire logic                cpu_locked;
	wire logic                cpu_wr_ok;
	wire logic                cpu_wr_sup;
	wire pmp_pkg::pmp_region_t cpu_region;
	wire logic                ext_take;
	wire logic                ext_mem_rd;
	wire logic                ext_mem_wr;
	wire logic [31:0]         status_word;

	assign code_protect_n = config_q[pmp_pkg::CP_N_BIT];
	assign app_lock       = config_q[pmp_pkg::APP_LOCK_BIT];
	assign saf_lock       = config_q[pmp_pkg::SAF_LOCK_BIT];
	assign boot_lock      = config_q[pmp_pkg::BOOT_LOCK_BIT];
	assign cfg_lock       = config_q[pmp_pkg::CFG_LOCK_BIT];

	assign data_protect_n = config_q[pmp_pkg::DATA_CP_N_BIT];

	// Zero wait states; every transfer is answered OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ahb_go    = hsel && hready && htrans[1];
	assign cfg_wr    = wr_pend && (ph_addr == pmp_pkg::CONFIG_OFS);
	assign sts_wr    = wr_pend && (ph_addr == pmp_pkg::STATUS_OFS);

	assign status_word = {cpu_cnt, ext_cnt};

	// Mux of flip-flops; a read right after a write sees the new value
	assign hrdata = !rd_pend ? 32'h0000_0000 :
		(ph_addr == pmp_pkg::CONFIG_OFS) ? config_q :
		(ph_addr == pmp_pkg::STATUS_OFS) ? status_word : 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			ph_addr <= 12'h000;
		end else begin
			wr_pend <= ahb_go && hwrite;
			rd_pend <= ahb_go && !hwrite;
			if (ahb_go) begin
				ph_addr <= haddr[11:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			config_q <= pmp_pkg::CONFIG_RST;
		end else if (cfg_wr) begin
			config_q <= hwdata & 32'h0000_011F;
		end
	end

	// CPU side: reads pass untouched, writes checked by region only
	pmp_region_chk #(
		.ADDR_W     (ADDR_W),
		.BOOT_WORDS (BOOT_WORDS),
		.SAF_WORDS  (SAF_WORDS)
	) u_region (
		.addr                     (cpu_addr),
		.cfg_space                (cpu_cfg_space),
		.app_region_write_lock    (app_lock),
		.storage_area_write_lock  (saf_lock),
		.boot_region_write_lock   (boot_lock),
		.config_region_write_lock (cfg_lock),
		.region                   (cpu_region),
		.locked                   (cpu_locked)
	);

	assign cpu_wr_ok  = cpu_wr_req && !cpu_rd_req && !cpu_locked;
	assign cpu_wr_sup = cpu_wr_req && !cpu_rd_req && cpu_locked;
	assign cpu_busy   = cpu_rd_req || cpu_wr_req;

	pmp_ext_gate #(
		.DATA_W (DATA_W)
	) u_ext (
		.core_clk       (core_clk),
		.srst           (srst),
		.ext_req        (ext_req),
		.ext_we         (ext_we),
		.code_protect_n (code_protect_n),
		.grant          (!cpu_busy),
		.rd_done        (rd2_ext),
		.mem_rdata      (mem_rdata),
		.ext_take       (ext_take),
		.ext_mem_rd     (ext_mem_rd),
		.ext_mem_wr     (ext_mem_wr),
		.ext_ack        (ext_ack),
		.ext_refused    (ext_refused),
		.ext_rdata      (ext_rdata)
	);

	// Memory port: CPU first, external only when the CPU is quiet
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mem_rd_en     <= 1'b0;
			mem_wr_en     <= 1'b0;
			mem_erase     <= 1'b0;
			mem_cfg_space <= 1'b0;
			mem_addr      <= '0;
			mem_wdata     <= '0;
		end else begin
			mem_rd_en     <= cpu_rd_req || ext_mem_rd;
			mem_wr_en     <= cpu_wr_ok || ext_mem_wr;
			mem_erase     <= cpu_wr_ok && cpu_erase;
			mem_cfg_space <= cpu_busy ? cpu_cfg_space : ext_cfg_space;
			mem_addr      <= cpu_busy ? cpu_addr : ext_addr;
			mem_wdata     <= cpu_busy ? cpu_wdata : ext_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd1_cpu      <= 1'b0;
			rd1_ext      <= 1'b0;
			rd2_cpu      <= 1'b0;
			rd2_ext      <= 1'b0;
			cpu_rd_valid <= 1'b0;
			cpu_rdata    <= '0;
		end else begin
			rd1_cpu      <= cpu_rd_req;
			rd1_ext      <= ext_mem_rd;
			rd2_cpu      <= rd1_cpu;
			rd2_ext      <= rd1_ext;
			cpu_rd_valid <= rd2_cpu;
			if (rd2_cpu) begin
				cpu_rdata <= mem_rdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cpu_wr_blocked <= 1'b0;
		end else begin
			cpu_wr_blocked <= cpu_wr_sup;
		end
	end

	// Event counters; a count in the clearing cycle survives the clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ext_cnt <= pmp_pkg::CNT_RST;
			cpu_cnt <= pmp_pkg::CNT_RST;
		end else begin
			ext_cnt <= (sts_wr ? pmp_pkg::CNT_RST : ext_cnt) +
				pmp_pkg::CNT_W'(ext_take && !code_protect_n);
			cpu_cnt <= (sts_wr ? pmp_pkg::CNT_RST : cpu_cnt) +
				pmp_pkg::CNT_W'(cpu_wr_sup);
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sequence ext_blocked_s;
		ext_take && !code_protect_n;
	endsequence

	sequence cpu_rd_path_s;
		##1 mem_rd_en ##2 cpu_rd_valid;
	endsequence

	data_indep_a: assert property (
		$changed(data_protect_n) |-> $past(cfg_wr))
		else $error("data protect bit changed without a write");

	cpu_read_a: assert property (
		cpu_rd_req && !code_protect_n |-> cpu_rd_path_s)
		else $error("CPU read blocked under code protection");

	cp_whole_a: assert property (
		ext_blocked_s |=> !mem_rd_en && !mem_wr_en)
		else $error("protected external access reached memory");

	ext_wr_block_a: assert property (
		ext_blocked_s ##0 ext_we |=> !mem_wr_en && ext_ack && ext_refused)
		else $error("protected external write not refused");

	ext_rd_zero_a: assert property (
		ext_blocked_s ##0 !ext_we |=> ext_ack && ext_rdata == '0)
		else $error("protected external read not zero");

	cpu_rd_any_a: assert property (
		cpu_rd_req |-> cpu_rd_path_s)
		else $error("CPU read did not complete in three cycles");

	cpu_wr_cp_a: assert property (
		cpu_wr_req && !cpu_rd_req && !cpu_locked |=> mem_wr_en)
		else $error("unlocked CPU write did not reach memory");

	lock_bits_a: assert property (
		cpu_region == pmp_pkg::PMP_REG_BOOT |-> cpu_locked == boot_lock)
		else $error("boot region lock not applied");

	app_open_a: assert property (
		cpu_wr_req && !cpu_rd_req && cpu_region == pmp_pkg::PMP_REG_APP
		&& !app_lock |=> mem_wr_en && !cpu_wr_blocked)
		else $error("app region write refused while unlocked");

	lock_sup_a: assert property (
		cpu_wr_req && !cpu_rd_req && cpu_locked
		|=> !mem_wr_en && !mem_erase && cpu_wr_blocked)
		else $error("write to locked region not suppressed");

	// A waiting external request must never steal the CPU's slot
	cpu_first_a: assert property (
		cpu_rd_req |=> mem_rd_en && mem_addr == $past(cpu_addr))
		else $error("CPU read lost the memory port");

endmodule : pmp_protect

//--- test/pmp_mem_model.sv
module pmp_mem_model #(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 14
) (
	input  wire logic              core_clk,
	input  wire logic              mem_rd_en,
	input  wire logic              mem_wr_en,
	input  wire logic              mem_erase,
	input  wire logic              mem_cfg_space,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_wdata,
	output logic      [DATA_W-1:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];
	wire  [ADDR_W:0]   idx = {mem_cfg_space, mem_addr};

	initial begin
		for (int i = 0; i < 2**(ADDR_W+1); i++) begin
			mem[i] = DATA_W'(i * 5);
		end
		mem_rdata = '0;
	end

	always @(posedge core_clk) begin
		// Erase leaves the word blank, the written data is not used
		if (mem_wr_en) begin
			mem[idx] <= mem_erase ? '1 : mem_wdata;
		end
		// Off the answer cycle the lines toggle so stale data never matches
		mem_rdata <= mem_rd_en ? mem[idx] : ~mem_rdata;
	end
endmodule : pmp_mem_model

//--- test/program_memory_protection_tb_top.sv
module program_memory_protection_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int AW = 11;
	localparam int DW = 14;
	logic core_clk = 0, srst = 1, hsel = 0, hwrite = 0;
	logic cpu_rd_req = 0, cpu_wr_req = 0, cpu_erase = 0, cpu_cfg_space = 0;
	logic ext_req = 0, ext_we = 0, ext_cfg_space = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rv, cv;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [AW-1:0] cpu_addr = 0, ext_addr = 0, mem_addr;
	logic [DW-1:0] cpu_wdata = 0, ext_wdata = 0;
	logic [DW-1:0] cpu_rdata, ext_rdata, mem_wdata, mem_rdata;
	logic hreadyout, hresp, cpu_rd_valid, cpu_wr_blocked, ext_ack;
	logic ext_refused, mem_rd_en, mem_wr_en, mem_erase, mem_cfg_space;
	logic data_protect_n;
	int errors = 0, samples_checked = 0, nblk, nref, a, lo, hi;
	int ref_mem [4096];

	initial forever #5 core_clk = ~core_clk;

	pmp_protect dut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.cpu_rd_req, .cpu_wr_req, .cpu_erase, .cpu_cfg_space, .cpu_addr,
		.cpu_wdata, .cpu_rdata, .cpu_rd_valid, .cpu_wr_blocked, .ext_req,
		.ext_we, .ext_cfg_space, .ext_addr, .ext_wdata, .ext_ack,
		.ext_refused, .ext_rdata, .mem_rd_en, .mem_wr_en, .mem_erase,
		.mem_cfg_space, .mem_addr, .mem_wdata, .mem_rdata, .data_protect_n);

	pmp_mem_model mem (.core_clk, .mem_rd_en, .mem_wr_en, .mem_erase,
		.mem_cfg_space, .mem_addr, .mem_wdata, .mem_rdata);

	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, exp, input string m);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : check

	// Samples in the late half so the values are those at the next edge
	task automatic bus_wait(output logic [31:0] d);
		logic r;
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			d = hrdata;
			r = hreadyout;
			@(posedge core_clk);
			n++;
		end while (r !== 1'b1 && n < 20);
		check(r, 1, "hready timeout");
	endtask : bus_wait

	task automatic ahb(input logic w, input logic [31:0] ad, wd,
		output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1;
		haddr <= ad;
		htrans <= 2'b10;
		hwrite <= w;
		bus_wait(rd);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= wd;
		bus_wait(rd);
		check(hresp, 0, "hresp");
	endtask : ahb

	task automatic cpu_rd(input logic c);
		int n;
		@(posedge core_clk);
		cpu_rd_req <= 1;
		cpu_addr <= AW'(a);
		cpu_cfg_space <= c;
		@(posedge core_clk);
		cpu_rd_req <= 0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (cpu_rd_valid !== 1'b1 && n < 10);
		check(n, 3, "cpu read latency");
		check(cpu_rdata, ref_mem[{c, AW'(a)}], "cpu read data");
	endtask : cpu_rd

	task automatic cpu_wr(input logic c, e, lk, input logic [DW-1:0] d);
		@(posedge core_clk);
		cpu_wr_req <= 1;
		cpu_erase <= e;
		cpu_addr <= AW'(a);
		cpu_cfg_space <= c;
		cpu_wdata <= d;
		@(posedge core_clk);
		cpu_wr_req <= 0;
		@(negedge core_clk);
		check(cpu_wr_blocked, lk, "cpu write blocked");
		check(mem_wr_en, !lk, "cpu write enable");
		if (!lk) ref_mem[{c, AW'(a)}] = e ? 'h3fff : d;
		else nblk++;
	endtask : cpu_wr

	task automatic ext(input logic w, c, cp_n, input logic [DW-1:0] d);
		int n;
		logic wr_seen, rd_seen;
		n = 0;
		wr_seen = 0;
		rd_seen = 0;
		@(posedge core_clk);
		ext_req <= 1;
		ext_we <= w;
		ext_addr <= AW'(a);
		ext_cfg_space <= c;
		ext_wdata <= d;
		do begin
			@(negedge core_clk);
			wr_seen |= mem_wr_en;
			rd_seen |= mem_rd_en;
			n++;
		end while (ext_ack !== 1'b1 && n < 10);
		check(ext_ack, 1, "ext ack");
		check(ext_refused, !cp_n, "ext refused");
		check(wr_seen, w & cp_n, "ext mem write");
		check(rd_seen, !w & cp_n, "ext mem read");
		if (!w) begin
			check(ext_rdata, cp_n ? ref_mem[{c, AW'(a)}] : 0,
				"ext rd");
		end
		if (w && cp_n) ref_mem[{c, AW'(a)}] = d;
		if (!cp_n) nref++;
		@(posedge core_clk);
		ext_req <= 0;
		@(posedge core_clk);
	endtask : ext

	initial begin
		#500_000;
		errors++;
		summarize;
	end

	initial begin
		void'($urandom(32'he487fa3c));
		for (int i = 0; i < 4096; i++) ref_mem[i] = (i * 5) & 'h3fff;
		repeat (12) @(posedge core_clk);
		srst <= 0;
		ahb(1, 32'h0000_0010, 32'hffff_ffff, rv);
		ahb(0, 32'h0000_0010, 0, rv);
		check(rv, 0, "unmapped read");
		ahb(0, pmp_pkg::CONFIG_OFS, 0, rv);
		check(rv, pmp_pkg::CONFIG_RST, "config reset");
		ahb(0, pmp_pkg::STATUS_OFS, 0, rv);
		check(rv, 0, "status reset");
		for (int v = 0; v < 64; v++) begin
			cv = 32'(v[4:0]) | (32'(v[5]) << pmp_pkg::DATA_CP_N_BIT);
			ahb(1, pmp_pkg::CONFIG_OFS, cv, rv);
			ahb(0, pmp_pkg::CONFIG_OFS, 0, rv);
			check(rv, cv, "config readback");
			@(negedge core_clk);
			check(data_protect_n, v[5], "data protect");
			nblk = 0;
			nref = 0;
			for (int r = 0; r < 4; r++) begin
				lo = (r == 0) ? pmp_pkg::BOOT_WORDS : 0;
				hi = (r == 2) ? pmp_pkg::BOOT_WORDS - 1 : 2047;
				if (r == 0) hi = 2047 - pmp_pkg::SAF_WORDS;
				if (r == 1) lo = 2048 - pmp_pkg::SAF_WORDS;
				a = (v % 3 == 0) ? lo : (v % 3 == 1) ? hi
					: lo + int'($urandom % (hi - lo + 1));
				// Lock bits follow region order app, storage, boot, config
				cpu_wr(r == 3, $urandom % 2, cv[pmp_pkg::APP_LOCK_BIT + r],
					DW'($urandom));
				cpu_rd(r == 3);
				ext(1, r == 3, v[0], DW'($urandom));
				ext(0, r == 3, v[0], 0);
				cpu_rd(r == 3);
			end
			ahb(0, pmp_pkg::STATUS_OFS, 0, rv);
			check(rv, {16'(nblk), 16'(nref)}, "status counts");
			ahb(1, pmp_pkg::STATUS_OFS, 0, rv);
		end
		// Read and write together with an external read waiting:
		// the CPU read wins the port and its write is dropped
		ahb(1, pmp_pkg::CONFIG_OFS, pmp_pkg::CONFIG_RST, rv);
		a = 700;
		@(posedge core_clk);
		cpu_rd_req <= 1;
		cpu_wr_req <= 1;
		cpu_erase <= 0;
		cpu_addr <= AW'(a);
		cpu_cfg_space <= 0;
		cpu_wdata <= DW'($urandom);
		ext_req <= 1;
		ext_we <= 0;
		ext_addr <= AW'(a + 1);
		ext_cfg_space <= 0;
		@(posedge core_clk);
		cpu_rd_req <= 0;
		cpu_wr_req <= 0;
		@(negedge core_clk);
		check(mem_wr_en, 0, "read beats write");
		check(mem_addr, a, "cpu owns the port");
		repeat (2) @(negedge core_clk);
		check(cpu_rd_valid, 1, "cpu read valid");
		check(cpu_rdata, ref_mem[a], "cpu read data");
		@(negedge core_clk);
		check(ext_ack, 1, "ext after cpu");
		check(ext_rdata, ref_mem[a + 1], "ext read data");
		@(posedge core_clk);
		ext_req <= 0;
		@(posedge core_clk);
		cpu_rd(0);
		// A second reset in mid-run restores CONFIG and clears STATUS
		ahb(1, pmp_pkg::CONFIG_OFS, 32'h0000_001E, rv);
		cpu_wr(0, 0, 1, DW'($urandom));
		ext(1, 0, 0, 0);
		@(posedge core_clk);
		srst <= 1;
		repeat (2) @(posedge core_clk);
		srst <= 0;
		ahb(0, pmp_pkg::CONFIG_OFS, 0, rv);
		check(rv, pmp_pkg::CONFIG_RST, "config after reset");
		ahb(0, pmp_pkg::STATUS_OFS, 0, rv);
		check(rv, 0, "status after reset");
		summarize;
	end
endmodule : program_memory_protection_tb_top
